//--- rtl/channel_source_and_pairing_ctrl.sv
/*
 * Source select and pairing configuration for ten low-side channels.
 * Decoded register writes arrive from the serial command front end on
 * clk_sys; input pins are asynchronous and synchronised here; serial on
 * bits and diagnosis detections come from logic on clk_sys.
 */
// Summary of operation
// - Select 0x: channel follows serial on bit
// - Select 10: channel follows its input pin
// - Select 11: on when serial bit and pin
// - All source selects reset to input mode
// - Bank A: channels 1-6, resets 0xaaa
// - Bank B: channels 7-10, upper zero
// - Paired: lower channel's source drives both
// - Pairing bits map adjacent channel pairs
// - No pairing across channel group boundaries
// - Pairing register resets to zero
// - Diagnosis fault stays on detecting channel
// - Device settings reset to 0x007
// - Serial on bit one means on
`timescale 1ns/1ns
`include "chan_src_params.svh"

module channel_source_and_pairing_ctrl (
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    input  wire logic                   clk_en,
    input  wire logic                   cmd_wr,
    input  wire logic [1:0]             cmd_sel,
    input  wire logic [`CSP_REG_W-1:0]  cmd_wdata,
    input  wire logic [`CSP_NUM_CH-1:0] serial_on_bit,
    input  wire logic [`CSP_NUM_CH-1:0] channel_input_pin,
    input  wire logic [`CSP_NUM_CH-1:0] diag_detect,
    output logic      [`CSP_NUM_CH-1:0] output_channel,
    output logic      [`CSP_NUM_CH-1:0] diag_fault,
    output logic      [`CSP_REG_W-1:0]  source_select_bank_a,
    output logic      [`CSP_REG_W-1:0]  source_select_bank_b,
    output logic      [`CSP_REG_W-1:0]  channel_pairing,
    output logic      [`CSP_REG_W-1:0]  device_settings
);

    chan_src_pkg::state_t state_q;
    chan_src_pkg::state_t state_d;

    // Flattened source selects, two bits per channel, channel 1 lowest.
    logic [2*`CSP_NUM_CH-1:0] channel_source_select;
    logic [`CSP_NUM_CH-1:0]   own_ctl;
    logic [`CSP_NUM_CH-1:0]   pair_into;
    logic [`CSP_NUM_CH-1:0]   eff_ctl;

    assign channel_source_select = {state_q.bank_b[7:0], state_q.bank_a};

    // Each channel's own command from its 2-bit source select.
    genvar gi;
    generate
        for (gi = 0; gi < `CSP_NUM_CH; gi++) begin : g_src
            logic [1:0] sel;
            assign sel = channel_source_select[2*gi +: 2];
            always_comb begin
                if (!sel[1]) begin
                    own_ctl[gi] = serial_on_bit[gi];
                end else if (sel == `CSP_MODE_INPUT) begin
                    own_ctl[gi] = state_q.pin_s2[gi];
                end else begin
                    own_ctl[gi] = serial_on_bit[gi] & state_q.pin_s2[gi];
                end
            end
        end
    endgenerate

    // A set bit makes channel i take channel i-1's control; channels 1, 5
    // and 7 open a group and can never be joined from below.
    assign pair_into = {state_q.pairing[7:5], 1'b0, state_q.pairing[4], 1'b0,
                        state_q.pairing[2:0], 1'b0};

    // Pairs resolve from channel 1 upward, so a run of set bits makes every
    // channel in the run follow the lowest channel of that run.
    always_comb begin
        eff_ctl[0] = own_ctl[0];
        for (int i = 1; i < `CSP_NUM_CH; i++) begin
            eff_ctl[i] = pair_into[i] ? eff_ctl[i-1] : own_ctl[i];
        end
    end

    // A low clock enable leaves state_d equal to state_q, which freezes the
    // pin chain, the outputs and the registers alike.
    always_comb begin
        state_d = state_q;
        if (clk_en) begin
            // Pins pass two flip-flops before any selector reads them.
            state_d.pin_s1  = channel_input_pin;
            state_d.pin_s2  = state_q.pin_s1;
            state_d.chan_on = eff_ctl;
            state_d.diag    = diag_detect;
            // Reserved bits are masked on entry, so they always read back as zero.
            if (cmd_wr) begin
                unique case (chan_src_pkg::reg_sel_t'(cmd_sel))
                    chan_src_pkg::REG_BANK_A:
                        state_d.bank_a = cmd_wdata & `CSP_MASK_BANK_A;
                    chan_src_pkg::REG_BANK_B:
                        state_d.bank_b = cmd_wdata & `CSP_MASK_BANK_B;
                    chan_src_pkg::REG_PAIRING:
                        state_d.pairing = cmd_wdata & `CSP_MASK_PAIRING;
                    chan_src_pkg::REG_DEV_SET:
                        state_d.dev_settings = cmd_wdata & `CSP_MASK_DEV_SET;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // Reset loads constants only; the sync chain and outputs clear.
            state_q              <= '0;
            state_q.bank_a       <= `CSP_RST_BANK_A;
            state_q.bank_b       <= `CSP_RST_BANK_B;
            state_q.pairing      <= `CSP_RST_PAIRING;
            state_q.dev_settings <= `CSP_RST_DEV_SET;
        end else begin
            state_q <= state_d;
        end
    end

    // Every output is a field of the registered state, never a gate.
    assign output_channel       = state_q.chan_on;
    assign diag_fault           = state_q.diag;
    assign source_select_bank_a = state_q.bank_a;
    assign source_select_bank_b = state_q.bank_b;
    assign channel_pairing      = state_q.pairing;
    assign device_settings      = state_q.dev_settings;

    // Assertions run on clk_sys and are off while reset is held, but a
    // check that looks one cycle back, such as $rose(arst_n), still sees the reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    chk_reset_defaults: assert property (
        $rose(arst_n)
        |-> state_q.bank_a == `CSP_RST_BANK_A
            && state_q.bank_b == `CSP_RST_BANK_B
            && state_q.pairing == `CSP_RST_PAIRING
            && state_q.dev_settings == `CSP_RST_DEV_SET)
        else $error("register defaults wrong after reset");

    chk_serial_mode: assert property (
        clk_en && !state_q.bank_a[1]
        |=> output_channel[0] == $past(serial_on_bit[0]))
        else $error("serial mode channel 1 wrong");

    chk_input_mode: assert property (
        clk_en && state_q.bank_a[1:0] == `CSP_MODE_INPUT
        |=> output_channel[0] == $past(state_q.pin_s2[0]))
        else $error("input mode channel 1 wrong");

    chk_and_mode: assert property (
        clk_en && state_q.bank_a[1:0] == `CSP_MODE_AND
        |=> output_channel[0] == ($past(serial_on_bit[0]) && $past(state_q.pin_s2[0])))
        else $error("and mode channel 1 wrong");

    chk_bank_a_write: assert property (
        clk_en && cmd_wr && cmd_sel == `CSP_SEL_BANK_A
        |=> source_select_bank_a == $past(cmd_wdata))
        else $error("bank a write not stored");

    chk_bank_b_write: assert property (
        clk_en && cmd_wr && cmd_sel == `CSP_SEL_BANK_B
        |=> source_select_bank_b == {4'h0, $past(cmd_wdata[7:0])})
        else $error("bank b write not stored or upper bits kept");

    chk_pairing_write: assert property (
        clk_en && cmd_wr && cmd_sel == `CSP_SEL_PAIRING
        |=> channel_pairing == {4'h0, $past(cmd_wdata[7:4]), 1'b0, $past(cmd_wdata[2:0])})
        else $error("pairing write not stored or reserved bits kept");

    chk_settings_write: assert property (
        clk_en && cmd_wr && cmd_sel == `CSP_SEL_DEV_SET
        |=> device_settings == $past(cmd_wdata))
        else $error("device settings write not stored");

    chk_reserved_zero: assert property (
        source_select_bank_b[11:8] == 4'h0 && channel_pairing[11:8] == 4'h0
        && !channel_pairing[3])
        else $error("reserved bits not zero");

    chk_pair_follow: assert property (
        clk_en && state_q.pairing[0]
        |=> output_channel[1] == output_channel[0])
        else $error("paired channel 2 not following channel 1");

    chk_pair_chain: assert property (
        clk_en && state_q.pairing[1:0] == 2'h3
        |=> output_channel[2] == output_channel[0])
        else $error("chained channel 3 not following channel 1");

    chk_pair_five_six: assert property (
        clk_en && state_q.pairing[4]
        |=> output_channel[5] == output_channel[4])
        else $error("paired channel 6 not following channel 5");

    chk_group_edge: assert property (
        clk_en && state_q.bank_a[9:8] == `CSP_MODE_INPUT
        |=> output_channel[4] == $past(state_q.pin_s2[4]))
        else $error("channel 5 joined across group boundary");

    chk_diag_single: assert property (
        clk_en
        |=> diag_fault == $past(diag_detect))
        else $error("diagnosis bit mirrored or lost");

    chk_enable_freeze: assert property (
        !clk_en
        |=> $stable(output_channel) && $stable(diag_fault)
            && $stable(source_select_bank_a) && $stable(channel_pairing))
        else $error("state moved while clock enable low");

    cov_pair_on: cover property (clk_en && state_q.pairing[0] && output_channel[0]);
    cov_and_mode: cover property (state_q.bank_a[1:0] == `CSP_MODE_AND && output_channel[0]);
    cov_bank_b_write: cover property (clk_en && cmd_wr && cmd_sel == `CSP_SEL_BANK_B);
    cov_pair_chain: cover property (state_q.pairing[1:0] == 2'h3 && output_channel[2]);
    cov_frozen_write: cover property (!clk_en && cmd_wr);

endmodule : channel_source_and_pairing_ctrl

//--- pkg/chan_src_params.svh
/*
 * Constants for the channel source and pairing control block: register
 * selects, reset values, writable masks, field layout and mode codes.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef CHAN_SRC_PARAMS_SVH
`define CHAN_SRC_PARAMS_SVH

`define CSP_NUM_CH        10
`define CSP_REG_W         12

`define CSP_SEL_BANK_A    2'h0
`define CSP_SEL_BANK_B    2'h1
`define CSP_SEL_PAIRING   2'h2
`define CSP_SEL_DEV_SET   2'h3

`define CSP_RST_BANK_A    12'haaa
`define CSP_RST_BANK_B    12'h0aa
`define CSP_RST_PAIRING   12'h000
`define CSP_RST_DEV_SET   12'h007

`define CSP_MASK_BANK_A   12'hfff
`define CSP_MASK_BANK_B   12'h0ff
`define CSP_MASK_PAIRING  12'h0f7
`define CSP_MASK_DEV_SET  12'hfff

`define CSP_MODE_INPUT    2'h2
`define CSP_MODE_AND      2'h3

`define CSP_BANK_A_CH     6

`endif

//--- pkg/chan_src_pkg.sv
/*
 * Types for the channel source and pairing control block.
 * Assumes chan_src_params.svh is on the include path.
 */
`include "chan_src_params.svh"

package chan_src_pkg;

    typedef enum logic [1:0] {
        REG_BANK_A  = 2'h0,
        REG_BANK_B  = 2'h1,
        REG_PAIRING = 2'h2,
        REG_DEV_SET = 2'h3
    } reg_sel_t;

    typedef struct packed {
        logic [`CSP_REG_W-1:0]  bank_a;
        logic [`CSP_REG_W-1:0]  bank_b;
        logic [`CSP_REG_W-1:0]  pairing;
        logic [`CSP_REG_W-1:0]  dev_settings;
        logic [`CSP_NUM_CH-1:0] pin_s1;
        logic [`CSP_NUM_CH-1:0] pin_s2;
        logic [`CSP_NUM_CH-1:0] chan_on;
        logic [`CSP_NUM_CH-1:0] diag;
    } state_t;

endpackage : chan_src_pkg

//--- bench/host_model.sv
/* Microcontroller-side model: decoded register writes and fault judging.
   Assumes the bench drives everything at the falling edge of clk_sys. */
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk_sys,
    input  wire logic [9:0] diag_fault,
    input  wire logic [9:0] pair_link,
    output logic            cmd_wr,
    output logic [1:0]      cmd_sel,
    output logic [11:0]     cmd_wdata,
    output logic [9:0]      joined_fault
);
    // A paired output is faulty when either of its two stages reports.
    assign joined_fault = diag_fault | ((diag_fault & pair_link) >> 1);
    initial begin
        cmd_wr = 1'b0;
        cmd_sel = 2'h0;
        cmd_wdata = 12'h000;
    end
    task automatic wr(input logic [1:0] sel, input logic [11:0] data);
        @(negedge clk_sys);
        cmd_sel = sel;
        cmd_wdata = data;
        cmd_wr = 1'b1;
        @(negedge clk_sys);
        cmd_wr = 1'b0;
    endtask : wr
endmodule : host_model

//--- bench/channel_source_and_pairing_ctrl_tb.sv
/* Self-checking bench for the channel source and pairing block.
   Assumes host_model.sv and the design are compiled first. */
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("FAIL %s exp %h got %h", n, e, a); end end
module channel_source_and_pairing_ctrl_tb;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic [9:0]  serial_on_bit = 10'h000;
    logic [9:0]  channel_input_pin = 10'h000;
    logic [9:0]  diag_detect = 10'h000;
    logic        clk_en = 1'b1;
    logic        cmd_wr;
    logic [1:0]  cmd_sel;
    logic [11:0] cmd_wdata, bank_a, bank_b, pairing, dev_set;
    logic [9:0]  output_channel, diag_fault, joined_fault;
    logic [19:0] sel_w = 20'haaaaa;
    logic [7:0]  pair_w = 8'h00;
    int          err_total = 0;
    int          samples_checked = 0;
    always #2 clk_sys = ~clk_sys;
    function automatic logic [9:0] link(input logic [7:0] pb);
        return {pb[7], pb[6], pb[5], 1'b0, pb[4], 1'b0, pb[2], pb[1], pb[0], 1'b0};
    endfunction : link
    channel_source_and_pairing_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
        .cmd_wr(cmd_wr), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
        .serial_on_bit(serial_on_bit), .channel_input_pin(channel_input_pin),
        .diag_detect(diag_detect), .output_channel(output_channel), .diag_fault(diag_fault),
        .source_select_bank_a(bank_a), .source_select_bank_b(bank_b),
        .channel_pairing(pairing), .device_settings(dev_set));
    host_model m (.clk_sys(clk_sys), .diag_fault(diag_fault), .pair_link(link(pairing[7:0])),
        .cmd_wr(cmd_wr), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .joined_fault(joined_fault));
    function automatic logic [9:0] model(input logic [9:0] s, input logic [9:0] p);
        logic [9:0] o;
        logic [9:0] pl;
        logic [1:0] md;
        pl = link(pair_w);
        for (int k = 0; k < 10; k++) begin
            md = sel_w[2*k +: 2];
            o[k] = md[1] ? (md[0] ? s[k] & p[k] : p[k]) : s[k];
            if (k > 0 && pl[k]) o[k] = o[k-1];
        end
        return o;
    endfunction : model
    task automatic sweep(input string name);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_sys);
            serial_on_bit = (i == 4) ? 10'h2a5 : {10{i[0]}};
            channel_input_pin = (i == 4) ? 10'h1b6 : {10{i[1]}};
            repeat (4) @(negedge clk_sys);
            `CHK("output_channel", model(serial_on_bit, channel_input_pin), output_channel)
        end
        $display("test %s done", name);
    endtask : sweep
    task automatic set_regs(input logic [11:0] a, input logic [11:0] b, input logic [11:0] pr);
        m.wr(2'h0, a);
        m.wr(2'h1, b);
        m.wr(2'h2, pr);
        sel_w = {b[7:0], a};
        pair_w = pr[7:0] & 8'hf7;
        @(negedge clk_sys);
        `CHK("bank_a", a, bank_a)
        `CHK("bank_b", b & 12'h0ff, bank_b)
        `CHK("pairing", pr & 12'h0f7, pairing)
    endtask : set_regs
    task automatic test_reset;
        repeat (4) @(negedge clk_sys);
        `CHK("bank_a", 12'haaa, bank_a)
        `CHK("bank_b", 12'h0aa, bank_b)
        `CHK("pairing", 12'h000, pairing)
        `CHK("dev_set", 12'h007, dev_set)
        @(negedge clk_sys);
        arst_n = 1'b1;
        sweep("reset");
    endtask : test_reset
    task automatic test_diag;
        m.wr(2'h3, 12'h5a5);
        @(negedge clk_sys);
        diag_detect = 10'h002;
        repeat (3) @(negedge clk_sys);
        `CHK("diag_fault", 10'h002, diag_fault)
        `CHK("joined_fault", 10'h003, joined_fault)
        `CHK("dev_set", 12'h5a5, dev_set)
        $display("test diag done");
    endtask : test_diag
    task automatic test_freeze;
        logic [9:0] held;
        @(negedge clk_sys);
        clk_en = 1'b0;
        held = model(serial_on_bit, channel_input_pin);
        serial_on_bit = ~serial_on_bit;
        channel_input_pin = ~channel_input_pin;
        m.wr(2'h0, 12'h000);
        repeat (3) @(negedge clk_sys);
        `CHK("frozen bank_a", 12'h6e7, bank_a)
        `CHK("frozen output_channel", held, output_channel)
        clk_en = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("output_channel", model(serial_on_bit, channel_input_pin), output_channel)
        $display("test freeze done");
    endtask : test_freeze
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
    initial begin
        test_reset();
        set_regs(12'hbe4, 12'hfff, 12'h000);
        sweep("modes");
        set_regs(12'hbe4, 12'hf1b, 12'hfff);
        sweep("pair_all");
        set_regs(12'h6e7, 12'h0e1, 12'h0a9);
        sweep("pair_some");
        test_freeze();
        test_diag();
        finish_test();
    end
endmodule : channel_source_and_pairing_ctrl_tb
